// >>> verilog/nsr_top.sv
// send/receive command decoder and transfer flag keeper
module nsr_top #(
   parameter int TIMEOUT_CYCLES = nsr_pkg::NSR_TIMEOUT_CYC,
   parameter int AREA_AW = 16
) (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic EXEC_I,
   input wire logic EXEC_COND_I,
   input wire logic NETWORK_RECEIVE_CMD_I,
   input wire nsr_pkg::nsr_ctrl_type CTRL_I,
   input wire logic [AREA_AW-1:0] DATA_BASE_I,
   input wire logic [AREA_AW-1:0] AREA_END_I,
   input wire logic PTR_INDIRECT_I,
   input wire logic [15:0] PTR_VALUE_I,
   input wire logic [15:0] DATA_MEM_WORDS_I,
   input wire logic [7:0] OWN_NODE_I,
   input wire logic LINK_MOUNTED_I,
   input wire logic PROGRAM_END_I,
   input wire logic LINK_DONE_I,
   input wire logic LINK_FAIL_I,
   output logic INSTR_ERROR_FLAG_O,
   output logic LINK_REQ_O,
   output nsr_pkg::nsr_req_type LINK_REQ_DATA_O,
   output logic TRANSFER_ENABLE_FLAG_O,
   output logic TRANSFER_ERROR_FLAG_O
);
   import nsr_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUSY = 3'b010,
      ST_DONE = 3'b100
   } nsr_state_type;

   nsr_state_type state_reg, state_next;
   logic err_reg;
   logic req_reg;
   nsr_req_type req_data_reg;
   logic en_reg;
   logic xerr_reg;
   logic node_err;
   logic field_err;
   logic timed_out;
   nsr_req_type req_dec;

   // mounted-unit pin comes from outside: two-stage synchroniser
   logic mnt_s1_reg, mnt_s2_reg;
   always_ff @(posedge MCLK_I) begin
      mnt_s1_reg <= LINK_MOUNTED_I;
      mnt_s2_reg <= mnt_s1_reg;
   end

   nsr_check u_check (
      .is_recv_i(NETWORK_RECEIVE_CMD_I),
      .own_node_i(OWN_NODE_I),
      .ctrl_i(CTRL_I),
      .node_err_o(node_err),
      .field_err_o(field_err),
      .req_o(req_dec)
   );

   nsr_timer #(.CYCLES(TIMEOUT_CYCLES)) u_timer (
      .MCLK_I(MCLK_I),
      .RST_I(RST_I),
      .run_i(state_reg == ST_BUSY),
      .expired_o(timed_out)
   );

   wire flat = CTRL_I.setup[NSR_BIT_FLAT];
   wire [15:0] max_len = flat ? NSR_FLAT_MAX_LEN : NSR_ROUTED_MAX_LEN;
   wire len_bad = CTRL_I.count > max_len;
   wire [AREA_AW:0] last_word = {1'b0, DATA_BASE_I} +
      {1'b0, CTRL_I.count[AREA_AW-1:0]};
   wire overrun = (CTRL_I.count != 16'h0) &&
      (last_word > {1'b0, AREA_END_I} + {{AREA_AW{1'b0}}, 1'b1});
   // pointer must be bcd and inside data memory
   logic [3:0] digit_bad;
   for (genvar g = 0; g < 4; g++) begin : g_bcd
      assign digit_bad[g] = PTR_VALUE_I[g*4 +: 4] > 4'h9;
   end
   wire ptr_not_bcd = |digit_bad;
   wire ptr_bad = PTR_INDIRECT_I &&
      (ptr_not_bcd || PTR_VALUE_I >= DATA_MEM_WORDS_I);
   wire no_unit = !mnt_s2_reg;
   wire any_err = node_err || field_err || len_bad || overrun ||
      ptr_bad || no_unit;
   // act only with condition true; only when enabled
   wire start = EXEC_I && EXEC_COND_I;
   wire launch = start && !any_err && en_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (launch) state_next = ST_BUSY;
         end
         ST_BUSY: begin
            if (LINK_DONE_I || LINK_FAIL_I || timed_out)
               state_next = ST_DONE;
         end
         ST_DONE: begin
            if (PROGRAM_END_I) state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) state_reg <= ST_IDLE;
      else state_reg <= state_next;
   end

   // error flag reflects the latest execution
   always_ff @(posedge MCLK_I) begin
      if (RST_I) err_reg <= 1'b0;
      else if (start) err_reg <= any_err;
   end

   // no request on decode error; request carries count
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         req_reg <= 1'b0;
         req_data_reg <= '0;
      end else begin
         req_reg <= launch;
         if (launch) req_data_reg <= req_dec;
      end
   end

   // enable low from launch to processed response
   always_ff @(posedge MCLK_I) begin
      if (RST_I) en_reg <= NSR_FLAG_ENABLE_RST;
      else if (launch) en_reg <= 1'b0;
      else if (state_reg == ST_DONE && PROGRAM_END_I) en_reg <= 1'b1;
   end

   // error kept until next transfer starts
   always_ff @(posedge MCLK_I) begin
      if (RST_I) xerr_reg <= NSR_FLAG_ERROR_RST;
      else if (launch) xerr_reg <= 1'b0;
      else if (state_reg == ST_BUSY && !LINK_DONE_I &&
               (LINK_FAIL_I || timed_out))
         xerr_reg <= 1'b1;
   end

   assign INSTR_ERROR_FLAG_O = err_reg;
   assign LINK_REQ_O = req_reg;
   assign LINK_REQ_DATA_O = req_data_reg;
   assign TRANSFER_ENABLE_FLAG_O = en_reg;
   assign TRANSFER_ERROR_FLAG_O = xerr_reg;
endmodule // nsr_top

// >>> verilog/nsr_pkg.sv
// package of constants and carriers for the network send/receive decoder
// Function
// - nothing happens while the execution condition is false
// - bit 15 of second word selects routed (0) or flat (1) network
// - routed second word low byte is network 0 to 127, 0 is local
// - bit 14 of second word set means level 0, clear level 1
// - routed send destination node 0 to 126, own node allowed
// - send to node zero broadcasts to every node
// - flat send node 0 to 62, not own node, third word high byte zero
// - flat low byte is response limit in tenths; 00 two seconds, ff none
// - flat bits 8 to 11 are retries, bit 12 must be zero
// - flat send bit 13 set means no response returned
// - routed receive source node 1 to 126, zero invalid
// - flat receive source node 0 to 62, third word high byte zero
// - send copies the word count from source to remote destination
// - error when node exceeds 126 routed or 62 flat
// - error when the words would run past their data area end
// - error on non-decimal or out-of-range indirect pointer
// - error and no transfer when no link unit is mounted
// - enable flag low from transfer start until response processed
// - transfer error set on failure or timeout, kept until next start
// - completion on response, link failure or timeout; enable at program end
package nsr_pkg;
   localparam logic [3:0] NSR_BIT_FLAT = 4'hf;
   localparam logic [3:0] NSR_BIT_LEVEL = 4'he;
   localparam logic [3:0] NSR_BIT_NORESP = 4'hd;
   localparam logic [3:0] NSR_BIT_ZERO12 = 4'hc;
   localparam logic [15:0] NSR_ROUTED_MAX_LEN = 16'h03e8;
   localparam logic [15:0] NSR_FLAT_MAX_LEN = 16'h0100;
   localparam logic [7:0] NSR_ROUTED_MAX_NET = 8'h7f;
   localparam logic [7:0] NSR_ROUTED_MAX_NODE = 8'h7e;
   localparam logic [7:0] NSR_FLAT_MAX_NODE = 8'h3e;
   localparam logic [7:0] NSR_LIMIT_DEFAULT = 8'h00;
   localparam logic [7:0] NSR_LIMIT_NONE = 8'hff;
   localparam int NSR_CLK_HZ = 50000000;
   localparam int NSR_TIMEOUT_MS = 1000;
   localparam int NSR_TIMEOUT_CYC = NSR_CLK_HZ / 1000 * NSR_TIMEOUT_MS;
   localparam logic NSR_FLAG_ENABLE_RST = 1'b1;
   localparam logic NSR_FLAG_ERROR_RST = 1'b0;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] setup;
      logic [15:0] node;
   } nsr_ctrl_type;

   typedef struct packed {
      logic is_recv;
      logic flat;
      logic level0;
      logic no_resp;
      logic [3:0] retries;
      logic [7:0] net_or_limit;
      logic [7:0] node;
      logic [7:0] port;
      logic [15:0] count;
   } nsr_req_type;
endpackage : nsr_pkg

// >>> verilog/nsr_check.sv
// combinational validation of the setup and node control words
module nsr_check (
   input wire logic is_recv_i,
   input wire logic [7:0] own_node_i,
   input wire nsr_pkg::nsr_ctrl_type ctrl_i,
   output logic node_err_o,
   output logic field_err_o,
   output nsr_pkg::nsr_req_type req_o
);
   import nsr_pkg::*;
   wire flat = ctrl_i.setup[NSR_BIT_FLAT];
   wire [7:0] lo = ctrl_i.setup[7:0];
   wire [7:0] node = ctrl_i.node[7:0];
   wire routed_node_bad = (node > NSR_ROUTED_MAX_NODE) ||
      (is_recv_i && node == 8'h00);
   wire flat_node_bad = (node > NSR_FLAT_MAX_NODE) ||
      (!is_recv_i && node == own_node_i && node != 8'h00);
   wire routed_fld_bad = lo > NSR_ROUTED_MAX_NET;
   // bit 12 zero, high byte zero
   wire flat_fld_bad = ctrl_i.setup[NSR_BIT_ZERO12] ||
      (ctrl_i.node[15:8] != 8'h00);
   assign node_err_o = flat ? flat_node_bad : routed_node_bad;
   assign field_err_o = flat ? flat_fld_bad : routed_fld_bad;
   always_comb begin
      req_o.is_recv = is_recv_i;
      req_o.flat = flat;
      req_o.level0 = ctrl_i.setup[NSR_BIT_LEVEL];
      // response suppression on flat send only
      req_o.no_resp = flat && !is_recv_i && ctrl_i.setup[NSR_BIT_NORESP];
      req_o.retries = flat ? ctrl_i.setup[11:8] : 4'h0;
      // limit or network number passed through
      req_o.net_or_limit = lo;
      // node zero is passed as broadcast
      req_o.node = node;
      req_o.port = flat ? 8'h00 : ctrl_i.node[15:8];
      req_o.count = ctrl_i.count;
   end
endmodule // nsr_check

// >>> verilog/nsr_timer.sv
// response timeout counter
module nsr_timer #(
   parameter int CYCLES = nsr_pkg::NSR_TIMEOUT_CYC
) (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic run_i,
   output logic expired_o
);
   import nsr_pkg::*;
   logic [31:0] cnt_reg;
   assign expired_o = run_i && (cnt_reg >= 32'(CYCLES));
   always_ff @(posedge MCLK_I) begin
      if (RST_I || !run_i) cnt_reg <= 32'h0;
      else if (!expired_o) cnt_reg <= cnt_reg + 32'h1;
   end
endmodule // nsr_timer

// >>> tb/nsr_assertions.sv
// concurrent checks on the send/receive decoder ports
module nsr_assertions (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic EXEC_I,
   input wire logic EXEC_COND_I,
   input wire nsr_pkg::nsr_ctrl_type CTRL_I,
   input wire logic LINK_MOUNTED_I,
   input wire logic PROGRAM_END_I,
   input wire logic LINK_DONE_I,
   input wire logic LINK_FAIL_I,
   input wire logic INSTR_ERROR_FLAG_O,
   input wire logic LINK_REQ_O,
   input wire logic TRANSFER_ENABLE_FLAG_O,
   input wire logic TRANSFER_ERROR_FLAG_O
);
   import nsr_pkg::*;
   logic go;
   assign go = EXEC_I && EXEC_COND_I && TRANSFER_ENABLE_FLAG_O;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   AST_IDLE: assert property (!(EXEC_I && EXEC_COND_I) |=> !LINK_REQ_O)
      else $error("request without command");
   AST_ERR_NO_REQ: assert property (LINK_REQ_O |-> !INSTR_ERROR_FLAG_O)
      else $error("request despite error");
   AST_UNMOUNTED: assert property (!LINK_MOUNTED_I [*3] ##0 go |=>
      INSTR_ERROR_FLAG_O && !LINK_REQ_O) else $error("no unit, no error");
   AST_ROUTED_NODE: assert property (go && !CTRL_I.setup[15] &&
      CTRL_I.node[7:0] > NSR_ROUTED_MAX_NODE |=> INSTR_ERROR_FLAG_O)
      else $error("routed node not refused");
   AST_FLAT_NODE: assert property (go && CTRL_I.setup[15] &&
      CTRL_I.node[7:0] > NSR_FLAT_MAX_NODE |=> INSTR_ERROR_FLAG_O)
      else $error("flat node not refused");
   AST_EN_FALL: assert property ($fell(TRANSFER_ENABLE_FLAG_O) |->
      LINK_REQ_O) else $error("enable fell without request");
   AST_EN_RISE: assert property ($rose(TRANSFER_ENABLE_FLAG_O) &&
      !$past(RST_I) |-> $past(PROGRAM_END_I)) else $error("enable rose early");
   AST_XERR: assert property (LINK_FAIL_I && !LINK_DONE_I &&
      !TRANSFER_ENABLE_FLAG_O |=> TRANSFER_ERROR_FLAG_O[*2])
      else $error("transfer error not kept");
endmodule // nsr_assertions

// >>> tb/nsr_link_model.sv
// link unit model answering transfer requests
module nsr_link_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [1:0] mode_i,
   input wire logic [3:0] dly_i,
   output logic done_o,
   output logic fail_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // one answer pulse; mode 2 stays silent
   initial begin
      done_o = 1'b0;
      fail_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (req_i && mode_i != 2'h2) begin
            repeat (dly_i + 1) @(negedge clk_i);
            done_o = (mode_i == 2'h0);
            fail_o = (mode_i == 2'h1);
            @(negedge clk_i);
            done_o = 1'b0;
            fail_o = 1'b0;
         end
      end
   end
endmodule // nsr_link_model

// >>> tb/test_nsr_top.sv
// self-checking bench for the send/receive decoder
module test_nsr_top;
   timeunit 1ns;
   timeprecision 1ns;
   import nsr_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, exec = 1'b0, cond = 1'b0, recv = 1'b0;
   logic ind = 1'b0, mnt = 1'b1, pend = 1'b0, done, fail, err, req, en, xerr;
   logic [15:0] base = 16'h0, aend = 16'h0, ptr = 16'h0123;
   logic [7:0] own = 8'h0, nd;
   logic [1:0] mode = 2'h0;
   logic [3:0] dly = 4'h0;
   logic [49:0] e, seen, q[$];
   logic f;
   nsr_ctrl_type ctrl = '0;
   nsr_req_type rdat;
   int n_errors = 0, n_tests = 0, k;
   always #10 mclk = ~mclk;
   always @(negedge mclk) pend = ($urandom_range(5) == 0);
   nsr_top #(.TIMEOUT_CYCLES(20), .AREA_AW(16)) i_nsr_top (.MCLK_I(mclk),
      .RST_I(rst), .EXEC_I(exec), .EXEC_COND_I(cond),
      .NETWORK_RECEIVE_CMD_I(recv), .CTRL_I(ctrl), .DATA_BASE_I(base),
      .AREA_END_I(aend), .PTR_INDIRECT_I(ind), .PTR_VALUE_I(ptr),
      .DATA_MEM_WORDS_I(16'h0200), .OWN_NODE_I(own), .LINK_MOUNTED_I(mnt),
      .PROGRAM_END_I(pend), .LINK_DONE_I(done), .LINK_FAIL_I(fail),
      .INSTR_ERROR_FLAG_O(err), .LINK_REQ_O(req), .LINK_REQ_DATA_O(rdat),
      .TRANSFER_ENABLE_FLAG_O(en), .TRANSFER_ERROR_FLAG_O(xerr));
   nsr_link_model i_nsr_link_model (.clk_i(mclk), .req_i(req),
      .mode_i(mode), .dly_i(dly), .done_o(done), .fail_o(fail));
   task automatic cmp(input logic [49:0] got, input logic [49:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_en();
      for (int t = 0; t < 200 && en !== 1'b1; t++)
         @(negedge mclk);
      if (en !== 1'b1) begin
         n_errors++;
         finish_test();
      end
   endtask
   function automatic logic [49:0] expect_of(input logic ok);
      logic x;
      nsr_req_type r;
      x = !mnt || (ind && ptr != 16'h0123);
      x = x || ({1'b0, base} + ctrl.count > {1'b0, aend} + 17'h1);
      if (ctrl.setup[15])
         x = x || ctrl.count > NSR_FLAT_MAX_LEN || ctrl.setup[12]
            || ctrl.node[7:0] > NSR_FLAT_MAX_NODE || ctrl.node[15:8] != 8'h0
            || (!recv && ctrl.node[7:0] != 8'h0 && ctrl.node[7:0] == own);
      else
         x = x || ctrl.count > NSR_ROUTED_MAX_LEN
            || ctrl.setup[7:0] > NSR_ROUTED_MAX_NET
            || ctrl.node[7:0] > NSR_ROUTED_MAX_NODE
            || (recv && ctrl.node[7:0] == 8'h0);
      r.is_recv = recv;
      r.flat = ctrl.setup[15];
      r.level0 = ctrl.setup[14];
      r.no_resp = ctrl.setup[15] && !recv && ctrl.setup[13];
      r.retries = ctrl.setup[15] ? ctrl.setup[11:8] : 4'h0;
      r.net_or_limit = ctrl.setup[7:0];
      r.node = ctrl.node[7:0];
      r.port = ctrl.setup[15] ? 8'h00 : ctrl.node[15:8];
      r.count = ctrl.count;
      if (!ok)
         return 50'h0;
      return x ? {2'b10, 48'h0} : {2'b01, r};
   endfunction
   always @(posedge mclk) begin
      if (!rst && exec && cond) begin
         @(negedge mclk);
         seen = {err, req, req ? rdat : 48'h0};
         cmp(seen, q.pop_front());
      end
   end
   initial begin
      k = $urandom(32'hbad7a3a4);
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 60; i++) begin
         wait_en();
         k = $urandom_range(9);
         mnt = (k != 0);
         ind = $urandom_range(1);
         ptr = k == 1 ? 16'h12a4 : (k == 2 ? 16'h9999 : 16'h0123);
         recv = $urandom_range(1);
         cond = $urandom_range(7) != 0;
         // the three control words always travel as one group
         ctrl.setup = 16'($urandom);
         f = ctrl.setup[15];
         ctrl.setup[12] = f && k == 3;
         // routed reserved bits clear; one network number too large
         if (!f)
            ctrl.setup[13:7] = {6'h0, k == 3};
         if (f && recv)
            ctrl.setup[13] = 1'b0;
         own = 8'($urandom_range(62));
         nd = f ? 8'($urandom_range(62)) : 8'($urandom_range(126));
         if (k == 5)
            nd = f ? 8'h3f : 8'h7f;
         if (k == 6)
            nd = f ? 8'h3e : 8'h7e;
         if (k == 7)
            nd = own;
         ctrl.node = {f ? 8'(k == 4) : 8'($urandom_range(2)), nd};
         // length within range except one case
         ctrl.count = 16'($urandom_range(f ? 256 : 1000));
         if (k == 8)
            ctrl.count = f ? 16'h0101 : 16'h03e9;
         base = 16'($urandom_range(200));
         aend = k == 9 ? base + ctrl.count - 16'h1 : 16'h0400;
         mode = 2'($urandom_range(2));
         dly = 4'($urandom);
         repeat (3) @(negedge mclk);
         e = expect_of(en === 1'b1);
         if (cond)
            q.push_back(e);
         exec = 1'b1;
         @(negedge mclk);
         if (i % 4 == 0) begin
            if (cond)
               q.push_back(expect_of(!e[48]));
            @(negedge mclk);
         end
         exec = 1'b0;
         if (cond && e[48]) begin
            wait_en();
            cmp_flag(xerr, mode != 2'h0);
         end
      end
      $display("random decode test done");
      finish_test();
   end
endmodule // test_nsr_top
bind nsr_top nsr_assertions i_nsr_assertions (.MCLK_I(MCLK_I), .RST_I(RST_I),
   .EXEC_I(EXEC_I), .EXEC_COND_I(EXEC_COND_I), .CTRL_I(CTRL_I),
   .LINK_MOUNTED_I(LINK_MOUNTED_I), .PROGRAM_END_I(PROGRAM_END_I),
   .LINK_DONE_I(LINK_DONE_I), .LINK_FAIL_I(LINK_FAIL_I),
   .INSTR_ERROR_FLAG_O(INSTR_ERROR_FLAG_O), .LINK_REQ_O(LINK_REQ_O),
   .TRANSFER_ENABLE_FLAG_O(TRANSFER_ENABLE_FLAG_O),
   .TRANSFER_ERROR_FLAG_O(TRANSFER_ERROR_FLAG_O));
